//--- rtl/branch_increment_pkg.sv
// package: encodings, field positions, widths and reset values for the block
package branch_increment_pkg;

    // =========================================================
    // widths
    localparam int INSTR_W = 12;
    localparam int DATA_W  = 8;
    localparam int PC_W    = 11;
    localparam int FADDR_W = 5;
    localparam int LIT_W   = 9;

    // =========================================================
    // opcode matching: jump uses top 3 bits, increments top 6 bits
    localparam logic [2:0]  OP_JUMP      = 3'h5;
    localparam logic [5:0]  OP_INC       = 6'h0A;
    localparam logic [5:0]  OP_INC_SKIP  = 6'h0F;
    localparam int          JUMP_OP_LSB  = 9;
    localparam int          INC_OP_LSB   = 6;
    localparam int          DEST_BIT     = 5;

    // =========================================================
    // status register page bits and zero flag position
    localparam int          PAGE_HI      = 6;
    localparam int          PAGE_LO      = 5;
    localparam int          ZERO_BIT     = 2;

    // =========================================================
    // reset values and constants
    localparam logic [DATA_W-1:0]  ACC_RESET = 8'h00;
    localparam logic [PC_W-1:0]    PC_RESET  = 11'h000;
    localparam logic [DATA_W-1:0]  ONE       = 8'h01;
    localparam logic [DATA_W-1:0]  ZERO      = 8'h00;

    // =========================================================
    // execute state: normal issue or flushing the prefetched word
    typedef enum logic [1:0] {
        ST_ISSUE = 2'b01,
        ST_FLUSH = 2'b10
    } exec_state_t;

    // register file write request
    typedef struct packed {
        logic               wr_en;
        logic [FADDR_W-1:0] addr;
        logic [DATA_W-1:0]  data;
    } reg_write_t;

    // program counter load request
    typedef struct packed {
        logic            load;
        logic [PC_W-1:0] target;
    } pc_load_t;

endpackage

//--- rtl/instr_class_decode.sv
// module: registered classifier of a fetched instruction word
`timescale 1ns/100ps
module instr_class_decode
(
    input  wire logic                                  ref_clk_i,
    input  wire logic                                  rst_b_i,
    input  wire logic                                  clk_en_i,
    input  wire logic                                  take_i,
    input  wire logic [branch_increment_pkg::INSTR_W-1:0] instr_i,
    output logic                                       is_jump_o,
    output logic                                       is_inc_o,
    output logic                                       is_inc_skip_o,
    output logic [branch_increment_pkg::INSTR_W-1:0]   instr_o
);
    import branch_increment_pkg::*;

    // =========================================================
    // decode the opcode field and hold the word for execute
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            is_jump_o     <= 1'b0;
            is_inc_o      <= 1'b0;
            is_inc_skip_o <= 1'b0;
            instr_o       <= '0;
        end
        else if (clk_en_i)
        begin
            is_jump_o <= take_i
                && (instr_i[INSTR_W-1:JUMP_OP_LSB] == OP_JUMP);
            is_inc_o  <= take_i
                && (instr_i[INSTR_W-1:INC_OP_LSB] == OP_INC);
            is_inc_skip_o <= take_i
                && (instr_i[INSTR_W-1:INC_OP_LSB] == OP_INC_SKIP);
            instr_o <= instr_i;
        end
    end

endmodule

//--- rtl/branch_increment_exec.sv
// module: execute logic for jump, increment and increment-skip-on-zero
`timescale 1ns/100ps
module branch_increment_exec
(
    input  wire logic                                  ref_clk_i,
    input  wire logic                                  rst_b_i,
    input  wire logic                                  clk_en_i,
    input  wire logic                                  instr_valid_i,
    input  wire logic [branch_increment_pkg::INSTR_W-1:0] instr_i,
    input  wire logic [branch_increment_pkg::DATA_W-1:0]  status_i,
    input  wire logic [branch_increment_pkg::DATA_W-1:0]  reg_rdata_i,
    output logic [branch_increment_pkg::FADDR_W-1:0]   reg_raddr_o,
    output branch_increment_pkg::reg_write_t           reg_write_o,
    output branch_increment_pkg::pc_load_t             pc_load_o,
    output logic [branch_increment_pkg::DATA_W-1:0]    acc_o,
    output logic                                       acc_wr_o,
    output logic                                       zero_wr_o,
    output logic                                       zero_o,
    output logic                                       flush_o,
    output logic                                       busy_o
);
    import branch_increment_pkg::*;

    // =========================================================
    // declarations
    exec_state_t               state;
    exec_state_t               next_state;
    logic                      is_jump;
    logic                      is_inc;
    logic                      is_inc_skip;
    logic [INSTR_W-1:0]        instr;
    logic                      take;
    logic [DATA_W-1:0]         sum;
    logic                      sum_zero;
    logic                      dest_reg;
    logic                      any_inc;
    logic                      skip_hit;
    logic                      ex_live;
    logic                      jump_hit;
    logic                      inc_hit;

    // every offered word is taken; the one fetched behind a jump or a
    // zero skip is turned into a no-op in execute instead
    assign take = instr_valid_i;

    // =========================================================
    // decode stage
    // opcode classes decoded
    instr_class_decode u_decode
    (
        .ref_clk_i     (ref_clk_i),
        .rst_b_i       (rst_b_i),
        .clk_en_i      (clk_en_i),
        .take_i        (take),
        .instr_i       (instr_i),
        .is_jump_o     (is_jump),
        .is_inc_o      (is_inc),
        .is_inc_skip_o (is_inc_skip),
        .instr_o       (instr)
    );

    // =========================================================
    // operand address goes out with the decoded word
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            reg_raddr_o <= '0;
        end
        else if (clk_en_i && take)
        begin
            reg_raddr_o <= instr_i[FADDR_W-1:0];
        end
    end

    // incrementer shared by both increment forms
    assign sum      = reg_rdata_i + ONE;
    assign sum_zero = (sum == ZERO);
    assign dest_reg = instr[DEST_BIT];
    assign ex_live  = (state == ST_ISSUE);
    assign jump_hit = is_jump && ex_live;
    assign inc_hit  = is_inc && ex_live;
    assign any_inc  = (is_inc || is_inc_skip) && ex_live;
    assign skip_hit = is_inc_skip && sum_zero && ex_live;

    // =========================================================
    // state: a jump or a zero skip forces one flush cycle
    always_comb
    begin
        next_state = state;
        case (state)
            ST_ISSUE:
            begin
                if (jump_hit || skip_hit)
                begin
                    next_state = ST_FLUSH;
                end
            end
            ST_FLUSH:
            begin
                next_state = ST_ISSUE;
            end
            default:
            begin
                next_state = ST_ISSUE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state <= ST_ISSUE;
        end
        else if (clk_en_i)
        begin
            state <= next_state;
        end
    end

    // =========================================================
    // program counter load on jump
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pc_load_o <= '{load: 1'b0, target: PC_RESET};
        end
        else if (clk_en_i)
        begin
            pc_load_o.load <= jump_hit;
            if (jump_hit)
            begin
                pc_load_o.target[LIT_W-1:0] <= instr[LIT_W-1:0];
                pc_load_o.target[PC_W-1:LIT_W] <=
                    status_i[PAGE_HI:PAGE_LO];
            end
        end
    end

    // =========================================================
    // result write-back to register file or accumulator
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            reg_write_o <= '{wr_en: 1'b0, addr: '0, data: ZERO};
            acc_o       <= ACC_RESET;
            acc_wr_o    <= 1'b0;
        end
        else if (clk_en_i)
        begin
            reg_write_o.wr_en <= any_inc && dest_reg;
            acc_wr_o          <= any_inc && !dest_reg;
            if (any_inc)
            begin
                reg_write_o.addr <= instr[FADDR_W-1:0];
                reg_write_o.data <= sum;
                if (!dest_reg)
                begin
                    acc_o <= sum;
                end
            end
        end
    end

    // =========================================================
    // zero flag: only the plain increment touches it
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            zero_wr_o <= 1'b0;
            zero_o    <= 1'b0;
        end
        else if (clk_en_i)
        begin
            zero_wr_o <= inc_hit;
            if (inc_hit)
            begin
                zero_o <= sum_zero;
            end
        end
    end

    // =========================================================
    // flush and busy indications to fetch
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            flush_o <= 1'b0;
            busy_o  <= 1'b0;
        end
        else if (clk_en_i)
        begin
            flush_o <= jump_hit || skip_hit;
            busy_o  <= (next_state == ST_FLUSH);
        end
    end

endmodule

//--- bench/branch_increment_sva.sv
// checker: concurrent properties on the execute block ports
`timescale 1ns/100ps
module branch_increment_sva
(
    input wire logic                             ref_clk_i,
    input wire logic                             rst_b_i,
    input wire logic                             clk_en_i,
    input wire logic                             instr_valid_i,
    input wire logic [11:0]                      instr_i,
    input wire logic [7:0]                       status_i,
    input wire logic [7:0]                       reg_rdata_i,
    input wire logic [4:0]                       reg_raddr_o,
    input wire branch_increment_pkg::reg_write_t reg_write_o,
    input wire branch_increment_pkg::pc_load_t   pc_load_o,
    input wire logic [7:0]                       acc_o,
    input wire logic                             acc_wr_o,
    input wire logic                             zero_wr_o,
    input wire logic                             zero_o,
    input wire logic                             flush_o,
    input wire logic                             busy_o
);
    import branch_increment_pkg::*;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i || !clk_en_i);
    // =========================================================
    // helper terms: accepted word and result of an increment
    logic       take;
    logic [7:0] res;
    assign take = clk_en_i && instr_valid_i;
    assign res  = acc_wr_o ? acc_o : reg_write_o.data;

    // a word is dropped when the cycle after its take is a flush cycle
    a_jump_target: assert property (take && instr_i[11:9] == OP_JUMP
        ##1 !busy_o |=> pc_load_o.load
            && pc_load_o.target[8:0] == $past(instr_i[8:0], 2))
        else $error("jump target low bits wrong");
    a_jump_page: assert property (pc_load_o.load
        |-> pc_load_o.target[10:9] == $past(status_i[6:5]))
        else $error("jump page bits wrong");
    a_jump_quiet: assert property (pc_load_o.load
        |-> flush_o && busy_o && !zero_wr_o && !acc_wr_o)
        else $error("jump touched flags or did not flush");
    a_inc_flag: assert property (take && instr_i[11:6] == OP_INC
        ##1 !busy_o |=> zero_wr_o && (acc_wr_o ^ reg_write_o.wr_en))
        else $error("increment missed its write or flag");
    a_zero_value: assert property (zero_wr_o
        |-> zero_o == (res == ZERO) && res == $past(reg_rdata_i) + ONE)
        else $error("zero flag does not match result");
    a_skip_noflag: assert property (
        take && instr_i[11:6] == OP_INC_SKIP ##1 !busy_o
        |=> !zero_wr_o && (acc_wr_o ^ reg_write_o.wr_en))
        else $error("skip increment wrote a flag");
    a_skip_flush: assert property (flush_o && !pc_load_o.load
        |-> res == ZERO && !zero_wr_o)
        else $error("flush without zero result");
    a_flush_once: assert property (flush_o
        |=> !flush_o && !busy_o && !pc_load_o.load
            && !acc_wr_o && !reg_write_o.wr_en && !zero_wr_o)
        else $error("flush too long or dropped word executed");
    a_read_index: assert property (take && instr_i[11:7] == 5'h05
        |-> ##1 reg_raddr_o == $past(instr_i[4:0]))
        else $error("register index not presented");
endmodule

//--- bench/tb.sv
// testbench: directed scenarios for the execute block
`timescale 1ns/100ps
module tb;
    import branch_increment_pkg::*;
    logic        ref_clk_i, rst_b_i, clk_en_i, instr_valid_i;
    logic [11:0] instr_i;
    logic [7:0]  status_i, reg_rdata_i, acc_o, g_acc, g_wd;
    logic [4:0]  reg_raddr_o, g_wa;
    logic [10:0] g_tg;
    logic        acc_wr_o, zero_wr_o, zero_o, flush_o, busy_o;
    logic        g_aw, g_zw, g_z, g_ld, g_fl, g_rw;
    reg_write_t  reg_write_o;
    pc_load_t    pc_load_o;
    int          errors, n_checks;

    branch_increment_exec dut_u (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
        .clk_en_i(clk_en_i), .instr_valid_i(instr_valid_i),
        .instr_i(instr_i), .status_i(status_i), .reg_rdata_i(reg_rdata_i),
        .reg_raddr_o(reg_raddr_o), .reg_write_o(reg_write_o),
        .pc_load_o(pc_load_o), .acc_o(acc_o), .acc_wr_o(acc_wr_o),
        .zero_wr_o(zero_wr_o), .zero_o(zero_o), .flush_o(flush_o),
        .busy_o(busy_o));

    // =========================================================
    // shared tasks: compare, verdict, one word and its results
    task automatic chk(input string nm, input logic [11:0] e, g);
        n_checks++;
        if (g !== e)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic final_report();
        if (errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // offer one word, hold read data, gather pulses for four cycles
    task automatic run_op(input logic [11:0] w, input logic [7:0] rd, st);
        @(negedge ref_clk_i);
        instr_i = w;
        instr_valid_i = 1'b1;
        reg_rdata_i = rd;
        status_i = st;
        {g_aw, g_zw, g_ld, g_fl, g_rw} = '0;
        {g_acc, g_z, g_tg, g_wd, g_wa} = 'x;
        @(negedge ref_clk_i);
        instr_valid_i = 1'b0;
        repeat (4)
        begin
            @(negedge ref_clk_i);
            g_aw |= acc_wr_o;
            g_zw |= zero_wr_o;
            g_ld |= pc_load_o.load;
            g_fl |= flush_o;
            g_rw |= reg_write_o.wr_en;
            if (acc_wr_o) g_acc = acc_o;
            if (zero_wr_o) g_z = zero_o;
            if (pc_load_o.load) g_tg = pc_load_o.target;
            if (reg_write_o.wr_en)
                {g_wa, g_wd} = {reg_write_o.addr, reg_write_o.data};
        end
    endtask

    // =========================================================
    // scenarios
    task automatic t_jump(input logic [11:0] w, input logic [7:0] st,
                          input logic [10:0] tg);
        run_op(w, 8'h3C, st);
        chk("load", 12'h001, g_ld);
        chk("target", tg, g_tg);
        chk("flags", 12'h000, {g_zw, g_aw, g_rw});
        chk("flush", 12'h001, g_fl);
    endtask

    task automatic t_inc(input logic [11:0] w, input logic [7:0] rd, ev,
                         input logic ez);
        run_op(w, rd, 8'h00);
        chk("dest", {w[5], !w[5]}, {g_rw, g_aw});
        chk("value", ev, w[5] ? g_wd : g_acc);
        if (w[5]) chk("addr", w[4:0], g_wa);
        chk("zero", {1'b1, ez}, {g_zw, g_z});
        chk("noflush", 12'h000, g_fl);
    endtask

    task automatic t_skip(input logic [11:0] w, input logic [7:0] rd, ev);
        run_op(w, rd, 8'h00);
        chk("dest", {w[5], !w[5]}, {g_rw, g_aw});
        chk("value", ev, w[5] ? g_wd : g_acc);
        if (w[5]) chk("addr", w[4:0], g_wa);
        chk("noflag", 12'h000, g_zw);
        chk("skip", ev == 8'h00, g_fl);
    endtask

    // the word fetched behind a jump or zero skip is dropped, the next runs
    task automatic t_refused(input logic [11:0] w, input logic [7:0] rd);
        run_op(12'hA10, 8'h00, 8'h00);
        run_op(12'h000, 8'h00, 8'h00);
        chk("other", 12'h000, {g_aw, g_zw, g_ld, g_fl, g_rw});
        @(negedge ref_clk_i);
        instr_i = w;
        instr_valid_i = 1'b1;
        reg_rdata_i = rd;
        @(negedge ref_clk_i);
        instr_i = 12'h283;
        @(negedge ref_clk_i);
        chk("busy", 12'h001, busy_o);
        instr_i = 12'h2A3;
        reg_rdata_i = 8'h07;
        @(negedge ref_clk_i);
        instr_valid_i = 1'b0;
        chk("discard", 12'h000, {acc_wr_o, reg_write_o.wr_en, busy_o});
        @(negedge ref_clk_i);
        chk("next", 12'h108, {reg_write_o.wr_en, reg_write_o.data});
    endtask

    // a jump caught by a low clock enable waits, then executes once
    task automatic t_freeze();
        @(negedge ref_clk_i);
        instr_i = 12'hA10;
        instr_valid_i = 1'b1;
        g_ld = 1'b0;
        @(negedge ref_clk_i);
        {instr_valid_i, clk_en_i} = 2'b00;
        repeat (3)
        begin
            @(negedge ref_clk_i);
            g_ld |= pc_load_o.load;
        end
        chk("stall", 12'h000, g_ld);
        clk_en_i = 1'b1;
        @(negedge ref_clk_i);
        chk("resume", 12'h003, {pc_load_o.load, busy_o});
    endtask

    // =========================================================
    // clock, reset, sequence and watchdog
    initial
    begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    initial
    begin
        {rst_b_i, clk_en_i, instr_valid_i} = 3'b010;
        {instr_i, status_i, reg_rdata_i} = '0;
        repeat (8) @(negedge ref_clk_i);
        rst_b_i = 1'b1;
        t_jump(12'hB5A, 8'h60, 11'h75A);
        t_jump(12'hA00, 8'h20, 11'h200);
        t_inc(12'h283, 8'h41, 8'h42, 1'b0);
        t_inc(12'h2BF, 8'hFF, 8'h00, 1'b1);
        t_skip(12'h3E5, 8'hFF, 8'h00);
        t_skip(12'h3C2, 8'h10, 8'h11);
        t_refused(12'hA10, 8'h00);
        t_refused(12'h3E5, 8'hFF);
        t_freeze();
        final_report();
    end

    initial
    begin
        #20000;
        errors++;
        final_report();
    end
endmodule

bind branch_increment_exec branch_increment_sva chk_u
(
    .ref_clk_i     (ref_clk_i),
    .rst_b_i       (rst_b_i),
    .clk_en_i      (clk_en_i),
    .instr_valid_i (instr_valid_i),
    .instr_i       (instr_i),
    .status_i      (status_i),
    .reg_rdata_i   (reg_rdata_i),
    .reg_raddr_o   (reg_raddr_o),
    .reg_write_o   (reg_write_o),
    .pc_load_o     (pc_load_o),
    .acc_o         (acc_o),
    .acc_wr_o      (acc_wr_o),
    .zero_wr_o     (zero_wr_o),
    .zero_o        (zero_o),
    .flush_o       (flush_o),
    .busy_o        (busy_o)
);
